/* include/host_access_consts.svh */
// constants of the host access block: offsets, codes, counts
`ifndef HOST_ACCESS_CONSTS_SVH
`define HOST_ACCESS_CONSTS_SVH
// internal procedure length in reference clock cycles
`define PROC_CYCLES  2'h3
// parallel offsets on address bits 1..0
`define OFS_CMD      2'h0
`define OFS_LO       2'h1
`define OFS_MID      2'h2
`define OFS_HI       2'h3
// type field of the selection byte
`define KIND_WRITE   2'h0
`define KIND_READ    2'h1
`define KIND_PORT    2'h2
`define KIND_STATUS  2'h3
// command codes
`define REG_SEL_MASK 8'hF0
`define REG_SEL_CODE 8'h80
`define SI_A_CODE    8'h8E
`define SI_B_CODE    8'h8F
// axes built into this part
`define AXES_PRESENT 4'h3
// serial frame lengths in bits and bytes
`define CMD_BITS     7'h10
`define SI_BITS      7'h18
`define DATA_BYTES   4'hC
// reset values
`define WBUF_RESET   8'h00
`endif

/* include/host_access_pkg.sv */
// types shared by the host access block
package host_access_pkg;
  typedef struct packed {
    logic [1:0] device;
    logic [1:0] kind;
    logic [3:0] axes;
  } sel_byte_t;
  typedef struct packed {
    logic [3:0] axes;
    logic [7:0] code;
  } cmd_write_t;
  typedef struct packed {
    logic [3:0]       axes;
    logic [3:0][23:0] data;
  } reg_write_t;
  typedef struct packed {
    logic       sel_b;
    logic [7:0] data;
  } si_write_t;
  typedef enum logic [1:0] { IDLE, FETCH, APPLY } commit_state_t;
endpackage : host_access_pkg

/* hw/pin_sync3.sv */
// three flip-flop synchroniser with agreement filter
module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk) begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end

  // a bit changes only once the second and third stage agree
  always_ff @(posedge clk) begin
    q <= (s2 & s3) | (q & (s2 ^ s3));
  end
endmodule : pin_sync3

/* hw/frame_byte_mem.sv */
// byte store for serial data, written on sck, read on clk
module frame_byte_mem (
  input  wire logic       wclk,
  input  wire logic       we,
  input  wire logic [3:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       clk,
  input  wire logic [3:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:15];

  always_ff @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule : frame_byte_mem

/* hw/host_access_ctrl.sv */
// host access: parallel wait control and serial frame decoding
`include "host_access_consts.svh"

// Notes on behaviour
// - command or low register byte write starts an internal procedure
// - new parallel access during a procedure pulls wait_request_n low
// - after a register selection command, only reads are stalled
// - parallel port starts in legacy mode; serial port has none
// - serial moves in bytes: selection, command, data; output off first
// - axis bits select axes; all zero selects the X axis alone
// - missing axes ignore writes and read back zero
// - type field picks write, read, port status or main status
// - only a matching device number answers; others stay undriven
// - a two byte command frame commits to the selected axes at slave select rise
// - register data follows per axis, low byte first, ascending axes
// - serial register data commits once its bytes are fetched after slave select rise
// - one axis may omit bytes; several axes use fixed 24 bit slots
// - bits a register lacks are ignored; host sends zeros there
// - single instance registers use three bytes, axis field ignored
// - single instance data commits at once, then frame is ignored
// - link works as mode 0 or 3, four devices per select line
// - serial front end runs on sck, the rest on clk
// - parallel offsets map command, status and register bytes
module host_access_ctrl
  import host_access_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             cs_n,
  input  wire logic             wr_n,
  input  wire logic             rd_n,
  input  wire logic [3:0]       addr,
  input  wire logic [7:0]       data_in,
  output logic      [7:0]       data_out,
  output logic                  data_oe,
  output logic                  wait_request_n,
  input  wire logic             sck,
  input  wire logic             ss_n,
  input  wire logic             mosi,
  output logic                  miso,
  output logic                  miso_oe,
  input  wire logic             device_select_pin_0,
  input  wire logic             device_select_pin_1,
  input  wire logic [3:0][7:0]  main_status_byte,
  input  wire logic [3:0][7:0]  port_status,
  input  wire logic [3:0][23:0] register_read_buffer,
  input  wire logic             legacy_escape_done,
  output logic                  serial_mode,
  output logic                  legacy_mode,
  output logic                  cmd_write_valid,
  output cmd_write_t            cmd_write,
  output logic                  reg_write_valid,
  output reg_write_t            reg_write,
  output logic                  si_write_valid,
  output si_write_t             si_write
);
  localparam logic [3:0] PRESENT = `AXES_PRESENT;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] eff_mask(input logic [3:0] m);
    eff_mask = (m == 4'h0) ? 4'h1 : m;
  endfunction : eff_mask

  function automatic logic is_regsel(input logic [7:0] c);
    is_regsel = (c & `REG_SEL_MASK) == `REG_SEL_CODE;
  endfunction : is_regsel

  function automatic logic is_si(input logic [7:0] c);
    is_si = (c == `SI_A_CODE) || (c == `SI_B_CODE);
  endfunction : is_si

  // position of the n-th selected axis, with a found flag on top
  function automatic logic [2:0] nth_axis(input logic [3:0] m,
                                          input logic [3:0] n);
    logic [3:0] seen;
    nth_axis = 3'h0;
    seen     = 4'h0;
    for (int a = 0; a < 4; a++) begin
      if (m[a]) begin
        if (seen == n) begin
          nth_axis = {1'b1, 2'(a)};
        end
        seen = seen + 4'h1;
      end
    end
  endfunction : nth_axis

  // hand each selected axis its own 24 bit slot, ascending
  function automatic logic [3:0][23:0] spread(
      input logic [3:0] m, input logic [11:0][7:0] b);
    int n;
    spread = '0;
    n      = 0;
    for (int a = 0; a < 4; a++) begin
      if (m[a]) begin
        spread[a] = {b[3*n+2], b[3*n+1], b[3*n]};
        n = n + 1;
      end
    end
  endfunction : spread

  // ----------------------------------------------------------------
  // pin synchronisers and straps
  // ----------------------------------------------------------------
  logic [5:0] pin_q;
  logic       si_tog;
  logic       si_tog_q;
  logic [1:0] dev_id;

  pin_sync3 #(.W(6)) u_pin_sync (
    .clk (clk),
    .d   ({cs_n, wr_n, rd_n, ss_n,
           device_select_pin_1, device_select_pin_0}),
    .q   (pin_q)
  );

  pin_sync3 #(.W(1)) u_si_sync (
    .clk (clk),
    .d   (si_tog),
    .q   (si_tog_q)
  );

  wire cs_q = pin_q[5];
  wire wr_q = pin_q[4];
  wire rd_q = pin_q[3];
  wire ss_q = pin_q[2];

  // port choice caught while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_mode <= !wr_q && !rd_q;
      legacy_mode <= wr_q || rd_q;
      dev_id      <= pin_q[1:0];
    end else if (legacy_escape_done) begin
      legacy_mode <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // serial front end on sck
  // ----------------------------------------------------------------
  logic [6:0] bitcnt;
  logic [6:0] shift;
  logic [6:0] last_bits;
  logic [7:0] cmd;
  logic [7:0] si_data;
  logic [7:0] tx_byte;
  logic [3:0] tx_idx;
  logic       si_lock;
  logic       si_is_b;
  sel_byte_t  sel;

  wire [7:0] rx_byte   = {shift, mosi};
  wire       dev_match = sel.device == dev_id;
  wire       byte_done = bitcnt[2:0] == 3'h7;
  wire       si_hit    = bitcnt == 7'h17 && !si_lock &&
                         sel.kind == `KIND_WRITE && dev_match &&
                         is_si(cmd);
  wire       mem_we    = byte_done && !si_lock && dev_match &&
                         sel.kind == `KIND_WRITE &&
                         bitcnt[6:3] >= 4'h2 && bitcnt[6:3] < 4'hE;

  // bit counter cleared whenever slave select is high
  always_ff @(posedge sck or posedge ss_n) begin
    if (ss_n) begin
      bitcnt <= 7'h00;
    end else if (!si_lock && bitcnt != 7'h7F) begin
      bitcnt <= bitcnt + 7'h01;
    end
  end

  // mosi sampled on rising sck
  always_ff @(posedge sck) begin
    shift <= {shift[5:0], mosi};
    if (bitcnt == 7'h07) begin
      sel <= sel_byte_t'(rx_byte);
    end
    if (bitcnt == 7'h0F) begin
      cmd <= rx_byte;
    end
    if (!si_lock) begin
      last_bits <= (bitcnt == 7'h7F) ? bitcnt : bitcnt + 7'h01;
    end
  end

  // single instance write is committed as soon as its byte is in;
  // the lock drops with slave select so the next frame loses no bit
  always_ff @(posedge sck or posedge ss_n) begin
    if (ss_n) begin
      si_lock <= 1'b0;
    end else if (si_hit) begin
      si_lock <= 1'b1;
    end
  end

  // toggle carries each single instance commit over to clk
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      si_tog <= 1'b0;
    end else if (si_hit) begin
      si_tog <= ~si_tog;
    end
  end

  always_ff @(posedge sck) begin
    if (si_hit) begin
      si_data <= rx_byte;
      si_is_b <= cmd == `SI_B_CODE;
    end
  end

  // ----------------------------------------------------------------
  // serial read data
  // ----------------------------------------------------------------
  logic [3:0][7:0]  ms_snap;
  logic [3:0][7:0]  ps_snap;
  logic [3:0][23:0] rd_snap;

  // snapshots stay frozen while a frame is open
  always_ff @(posedge clk) begin
    if (reset) begin
      ms_snap <= '0;
      ps_snap <= '0;
      rd_snap <= '0;
    end else if (ss_q) begin
      for (int a = 0; a < 4; a++) begin
        ms_snap[a] <= PRESENT[a] ? main_status_byte[a] : 8'h00;
        ps_snap[a] <= PRESENT[a] ? port_status[a] : 8'h00;
        rd_snap[a] <= PRESENT[a] ? register_read_buffer[a] : 24'h0;
      end
    end
  end

  assign tx_idx = bitcnt[6:3] - 4'h2;

  always_comb begin
    logic [2:0] pick;
    logic [3:0] slot;
    logic [1:0] pos;
    pick    = 3'h0;
    slot    = tx_idx;
    pos     = 2'h0;
    tx_byte = 8'h00;
    if (sel.kind == `KIND_READ) begin
      slot = tx_idx / 4'h3;
      pos  = 2'(tx_idx % 4'h3);
    end
    pick = nth_axis(eff_mask(sel.axes), slot);
    if (pick[2]) begin
      case (sel.kind)
        `KIND_READ:   tx_byte = rd_snap[pick[1:0]][8*pos +: 8];
        `KIND_PORT:   tx_byte = ps_snap[pick[1:0]];
        `KIND_STATUS: tx_byte = ms_snap[pick[1:0]];
        default:      tx_byte = 8'h00;
      endcase
    end
  end

  // miso changes on falling sck, off until the data bytes
  always_ff @(negedge sck or posedge ss_n) begin
    if (ss_n) begin
      miso    <= 1'b1;
      miso_oe <= 1'b0;
    end else begin
      miso    <= tx_byte[~bitcnt[2:0]];
      miso_oe <= dev_match && sel.kind != `KIND_WRITE &&
                 bitcnt >= `CMD_BITS && !si_lock;
    end
  end

  // ----------------------------------------------------------------
  // serial commit on clk
  // ----------------------------------------------------------------
  commit_state_t    state;
  logic [3:0]       ridx;
  logic [3:0]       nbytes;
  logic [7:0]       rdata;
  logic [11:0][7:0] fetched;
  logic             ss_prev;
  logic             si_prev;

  frame_byte_mem u_mem (
    .wclk  (sck),
    .we    (mem_we),
    .waddr (tx_idx),
    .wdata (rx_byte),
    .clk   (clk),
    .raddr (ridx),
    .rdata (rdata)
  );

  wire       ss_rise  = ss_q && !ss_prev && serial_mode;
  wire       frame_ok = sel.kind == `KIND_WRITE && dev_match &&
                        !si_lock && !is_si(cmd);
  wire       ser_cmd  = ss_rise && frame_ok && last_bits >= `CMD_BITS;
  wire [3:0] ser_axes = eff_mask(sel.axes) & PRESENT;
  wire       si_evt   = si_tog_q ^ si_prev;

  always_ff @(posedge clk) begin
    if (reset) begin
      ss_prev <= 1'b1;
      si_prev <= 1'b0;
    end else begin
      ss_prev <= ss_q;
      si_prev <= si_tog_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state   <= IDLE;
      ridx    <= 4'h0;
      nbytes  <= 4'h0;
      fetched <= '0;
    end else begin
      case (state)
        IDLE: begin
          if (ser_cmd && is_regsel(cmd) && last_bits >= `SI_BITS) begin
            state  <= FETCH;
            ridx   <= 4'h0;
            nbytes <= last_bits[6:3] - 4'h2;
          end
        end
        FETCH: begin
          if (ridx != 4'h0) begin
            fetched[ridx - 4'h1] <= (ridx - 4'h1 < nbytes) ?
                                    rdata : 8'h00;
          end
          if (ridx == `DATA_BYTES) begin
            state <= APPLY;
          end else begin
            ridx <= ridx + 4'h1;
          end
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // parallel port
  // ----------------------------------------------------------------
  logic [3:0] lat_addr;
  logic [7:0] lat_data;
  logic [7:0] wbuf_mid;
  logic [7:0] wbuf_hi;
  logic [1:0] proc_cnt;
  logic       wr_prev;
  logic       sel_only;

  wire       acc_wr = !serial_mode && !cs_q && !wr_q;
  wire       acc_rd = !serial_mode && !cs_q && !rd_q;
  wire       wr_end = wr_prev && !acc_wr;
  wire [1:0] ofs    = lat_addr[1:0];
  wire [3:0] onehot = 4'h1 << lat_addr[3:2];
  wire       busy   = proc_cnt != 2'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_prev  <= 1'b0;
      lat_addr <= 4'h0;
      lat_data <= 8'h00;
    end else begin
      wr_prev <= acc_wr;
      if (acc_wr) begin
        lat_addr <= addr;
        lat_data <= data_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wbuf_mid <= `WBUF_RESET;
      wbuf_hi  <= `WBUF_RESET;
    end else if (wr_end && ofs == `OFS_MID) begin
      wbuf_mid <= lat_data;
    end else if (wr_end && ofs == `OFS_HI) begin
      wbuf_hi  <= lat_data;
    end
  end

  // internal procedure timer
  always_ff @(posedge clk) begin
    if (reset) begin
      proc_cnt <= 2'h0;
      sel_only <= 1'b0;
    end else if (wr_end && (ofs == `OFS_CMD || ofs == `OFS_LO)) begin
      proc_cnt <= `PROC_CYCLES;
      sel_only <= ofs == `OFS_CMD && is_regsel(lat_data);
    end else if (busy) begin
      proc_cnt <= proc_cnt - 2'h1;
    end
  end

  assign wait_request_n = !(busy &&
                            (acc_rd || (acc_wr && !sel_only)));

  always_ff @(posedge clk) begin
    if (reset) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= acc_rd;
      if (acc_rd && wait_request_n) begin
        if (!PRESENT[addr[3:2]]) begin
          data_out <= 8'h00;
        end else if (addr[1:0] == `OFS_CMD) begin
          data_out <= main_status_byte[addr[3:2]];
        end else begin
          data_out <= register_read_buffer[addr[3:2]]
                      [8*(addr[1:0] - 2'h1) +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // commits toward the axes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_write_valid <= 1'b0;
      cmd_write       <= '0;
      reg_write_valid <= 1'b0;
      reg_write       <= '0;
      si_write_valid  <= 1'b0;
      si_write        <= '0;
    end else begin
      cmd_write_valid <= 1'b0;
      reg_write_valid <= 1'b0;
      si_write_valid  <= 1'b0;
      if (wr_end && ofs == `OFS_CMD) begin
        cmd_write_valid <= |(onehot & PRESENT);
        cmd_write       <= '{axes: onehot & PRESENT, code: lat_data};
      end else if (ser_cmd) begin
        cmd_write_valid <= |ser_axes;
        cmd_write       <= '{axes: ser_axes, code: cmd};
      end
      if (wr_end && ofs == `OFS_LO) begin
        reg_write_valid <= |(onehot & PRESENT);
        reg_write       <= '{axes: onehot & PRESENT,
                             data: {4{wbuf_hi, wbuf_mid, lat_data}}};
      end else if (state == APPLY) begin
        reg_write_valid <= |ser_axes;
        reg_write       <= '{axes: ser_axes,
                             data: spread(eff_mask(sel.axes), fetched)};
      end
      if (si_evt && serial_mode) begin
        si_write_valid <= 1'b1;
        si_write       <= '{sel_b: si_is_b, data: si_data};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_proc_run;
    busy [*3] ##1 !busy;
  endsequence

  property p_proc_start;
    @(posedge clk) disable iff (reset)
      wr_end && (ofs == `OFS_CMD || ofs == `OFS_LO) |=> s_proc_run;
  endproperty
  a_proc_start: assert property (p_proc_start)
    else $error("procedure did not run three cycles");

  property p_wait_cause;
    @(posedge clk) disable iff (reset)
      !wait_request_n |-> busy && (acc_rd || acc_wr);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("wait without a running procedure");

  property p_sel_write;
    @(posedge clk) disable iff (reset)
      busy && sel_only && acc_wr && !acc_rd |-> wait_request_n;
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("write stalled after selection command");

  property p_no_legacy;
    @(posedge clk) disable iff (reset)
      serial_mode |-> !legacy_mode && !data_oe;
  endproperty
  a_no_legacy: assert property (p_no_legacy)
    else $error("legacy mode on serial port");

  property p_miso_head;
    @(negedge sck) disable iff (ss_n)
      bitcnt < `CMD_BITS |=> !miso_oe;
  endproperty
  a_miso_head: assert property (p_miso_head)
    else $error("serial output driven in header bytes");

  property p_miso_write;
    @(negedge sck) disable iff (ss_n)
      sel.kind == `KIND_WRITE || !dev_match |=> !miso_oe;
  endproperty
  a_miso_write: assert property (p_miso_write)
    else $error("serial output driven on write or mismatch");

  property p_present_only;
    @(posedge clk) disable iff (reset)
      cmd_write_valid || reg_write_valid |->
        ((cmd_write.axes | reg_write.axes) & ~PRESENT) == 4'h0;
  endproperty
  a_present_only: assert property (p_present_only)
    else $error("write reached a missing axis");

  property p_ss_commit;
    @(posedge clk) disable iff (reset)
      ser_cmd && !is_regsel(cmd) && |ser_axes |=> cmd_write_valid;
  endproperty
  a_ss_commit: assert property (p_ss_commit)
    else $error("command not committed at select rise");

  property p_si_commit;
    @(posedge clk) disable iff (reset)
      si_evt && serial_mode |=> si_write_valid ##1 !si_write_valid;
  endproperty
  a_si_commit: assert property (p_si_commit)
    else $error("single instance write not committed once");

  property p_fetch_len;
    @(posedge clk) disable iff (reset)
      $rose(state == FETCH) |-> ##[12:13] state == APPLY;
  endproperty
  a_fetch_len: assert property (p_fetch_len)
    else $error("register data fetch length wrong");
endmodule : host_access_ctrl

/* tb/spi_host_model.sv */
// host cpu model: spi master in mode 0 driving the serial port
module spi_host_model (
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end
  // one frame, msb first, 80 ns clock only while selected
  task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    ss_n = 1'b0;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi = tx[i][k];
        #40 sck = 1'b1;
        b = {b[6:0], miso};
        #40 sck = 1'b0;
      end
      rx.push_back(b);
    end
    #40 ss_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask : xfer
endmodule : spi_host_model

/* tb/host_access_wait_and_serial_framing_tb.sv */
// testbench of the host access block, serial and parallel ports
module host_access_wait_and_serial_framing_tb
  import host_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // signals
  // ----
  logic clk = 0, reset = 0, cs_n = 1, wr_n = 0, rd_n = 0, esc = 0;
  logic ds0 = 0, ds1 = 1, lo, si_ss, cmd_v, reg_v, si_v;
  logic [3:0] addr = 4'h0;
  logic [7:0] data_in = 8'h00, data_out, d;
  logic data_oe, wait_request_n, sck, ss_n, mosi, miso, miso_oe;
  logic serial_mode, legacy_mode;
  logic [3:0][7:0] msb = '0, pst = '0;
  logic [3:0][23:0] rrb = '0;
  cmd_write_t cmd_w, cmd_c;
  reg_write_t reg_w, reg_c;
  si_write_t si_w, si_c;
  int num_errors = 0, total_checks = 0, seed = 89206;
  int cmd_n = 0, reg_n = 0, si_n = 0, oe_n = 0, a, o;
  logic [7:0] tx[$], rx[$], ex[$];
  logic [3:0] am[3] = '{4'h0, 4'hF, 4'h6};
  logic [3:0] ae[3] = '{4'h1, 4'h3, 4'h2};
  wire miso_w = miso_oe ? miso : 1'b1;
  always #25 clk = ~clk;
  host_access_ctrl dut_u (.clk, .reset, .cs_n, .wr_n, .rd_n, .addr,
    .data_in, .data_out, .data_oe, .wait_request_n, .sck, .ss_n, .mosi,
    .miso, .miso_oe, .device_select_pin_0(ds0), .device_select_pin_1(ds1),
    .main_status_byte(msb), .port_status(pst), .register_read_buffer(rrb),
    .legacy_escape_done(esc), .serial_mode, .legacy_mode,
    .cmd_write_valid(cmd_v), .cmd_write(cmd_w), .reg_write_valid(reg_v),
    .reg_write(reg_w), .si_write_valid(si_v), .si_write(si_w));
  spi_host_model model_u (.sck, .ss_n, .mosi, .miso(miso_w));
  always @(posedge clk) begin
    oe_n += miso_oe;
    if (cmd_v) begin
      cmd_n++;
      cmd_c = cmd_w;
    end
    if (reg_v) begin
      reg_n++;
      reg_c = reg_w;
    end
    if (si_v) begin
      si_n++;
      si_c = si_w;
      si_ss = ss_n;
    end
  end
  // ----
  // tasks
  // ----
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic await(ref int c, input int want);
    for (int i = 0; i < 80 && c < want; i++)
      @(posedge clk);
    chk(c >= want, "pulse timeout");
    if (c < want)
      close_out;
  endtask : await
  task do_reset(input logic ser);
    reset <= 1;
    wr_n <= !ser;
    rd_n <= !ser;
    repeat (5) @(posedge clk);
    reset <= 0;
    wr_n <= 1;
    rd_n <= 1;
    repeat (2) @(posedge clk);
  endtask : do_reset
  task automatic par(input logic w, input logic [3:0] ad,
                     input logic [7:0] dv, output logic l);
    l = 0;
    cs_n <= 0;
    wr_n <= !w;
    rd_n <= w;
    @(posedge clk);
    addr <= ad;
    data_in <= dv;
    for (int i = 0; i < 60 && (i < 10 || !wait_request_n); i++) begin
      @(negedge clk);
      l |= !wait_request_n;
    end
    chk(wait_request_n === 1'b1, "wait stuck");
    chk(data_oe === !w, "read enable");
    repeat (3) @(posedge clk);
    cs_n <= 1;
    wr_n <= 1;
    rd_n <= 1;
    repeat (3) @(posedge clk);
  endtask : par
  // ----
  // sequence
  // ----
  initial begin
    do_reset(1);
    chk(serial_mode === 1 && legacy_mode === 0, "serial strap");
    msb <= $random(seed);
    pst <= $random(seed);
    rrb <= {$random(seed), $random(seed), $random(seed)};
    for (int i = 0; i < 3; i++) begin
      a = cmd_n;
      o = oe_n;
      d = 8'($random(seed)) & 8'h7F;
      tx = '{{2'h2, 2'h0, am[i]}, d};
      model_u.xfer(tx, rx);
      await(cmd_n, a + 1);
      chk(cmd_c === {ae[i], d} && oe_n == o, "command");
    end
    tx = '{8'h40, 8'h01};
    model_u.xfer(tx, rx);
    repeat (20) @(posedge clk);
    chk(cmd_n == a + 1 && oe_n == o, "foreign device");
    $display("test command done");
    a = reg_n;
    tx = '{8'h83, 8'h80 | (8'($random(seed)) & 8'h07)};
    for (int i = 0; i < 6; i++)
      tx.push_back(8'($random(seed)));
    model_u.xfer(tx, rx);
    await(reg_n, a + 1);
    chk(reg_c.axes === 4'h3 && reg_c.data[0] === {tx[4], tx[3], tx[2]}
        && reg_c.data[1] === {tx[7], tx[6], tx[5]}, "reg");
    a = si_n;
    d = 8'($random(seed));
    tx = '{{4'h8, 4'($random(seed))}, 8'h8F, d, 8'h8E, 8'h55};
    model_u.xfer(tx, rx);
    await(si_n, a + 1);
    chk(si_c === {1'b1, d} && si_ss === 0 && si_n == a + 1, "si");
    $display("test write done");
    for (int k = 1; k < 4; k++) begin
      ex = {};
      for (int x = 0; x < 3; x += 2)
        if (k == 1)
          for (int b = 0; b < 3; b++)
            ex.push_back(x == 0 ? rrb[0][8*b+:8] : 8'h00);
        else
          ex.push_back(x == 0 ? (k == 2 ? pst[0] : msb[0]) : 8'h00);
      tx = '{{2'h2, k[1:0], 4'h5}, 8'h00};
      foreach (ex[i])
        tx.push_back(8'h00);
      model_u.xfer(tx, rx);
      chk(rx[0] === 8'hFF && rx[1] === 8'hFF, "hi-z");
      foreach (ex[i])
        chk(rx[i+2] === ex[i], "read byte");
    end
    $display("test read done");
    do_reset(0);
    chk(legacy_mode === 1 && serial_mode === 0, "legacy");
    esc <= 1;
    @(posedge clk);
    esc <= 0;
    repeat (4) @(posedge clk);
    chk(legacy_mode === 0, "escape");
    a = cmd_n;
    par(1, 4'h0, 8'h05, lo);
    par(0, 4'h0, 8'h00, lo);
    chk(lo === 1 && data_out === msb[0], "stalled read");
    chk(cmd_n == a + 1 && cmd_c === {4'h1, 8'h05}, "par cmd");
    a = reg_n;
    d = 8'($random(seed));
    par(1, 4'h0, 8'h82, lo);
    par(1, 4'h2, d, lo);
    chk(lo === 0, "write after select");
    par(1, 4'h3, ~d, lo);
    par(1, 4'h1, 8'h3C, lo);
    await(reg_n, a + 1);
    chk(reg_c.data[0] === {~d, d, 8'h3C} && reg_c.axes === 4'h1,
        "par reg");
    par(0, 4'h9, 8'h00, lo);
    chk(data_out === 8'h00, "missing axis read");
    $display("test parallel done");
    close_out;
  end
endmodule : host_access_wait_and_serial_framing_tb
